// ===== verilog/cis_cfg.svh
// Address map, field layout, reset values and timing for the interrupt selector
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

`define CIS_ADDR_SEL_HIGH   32'h019c0000
`define CIS_ADDR_SEL_LOW    32'h019c0004
`define CIS_ADDR_POLARITY   32'h019c0008
`define CIS_ADDR_STATUS     32'h019c000c
`define CIS_ADDR_MASK       32'h019c0010

`define CIS_SEL_WIDTH       5
`define CIS_FIELDS_PER_REG  6
`define CIS_FIELD_GAP_IDX   3
`define CIS_SEL_WMASK       32'h7fff7fff
`define CIS_RST_SEL_LOW     32'h250718a4
`define CIS_RST_SEL_HIGH    32'h08202d43

`define CIS_POL_WIDTH       4
`define CIS_RST_POLARITY    4'h0

`define CIS_NUM_LINES       16
`define CIS_FIRST_SEL_LINE  4
`define CIS_STAT_WMASK      16'hfff0
`define CIS_RST_MASK        16'h0000

`define CIS_SYNC_STAGES     2

`endif

// ===== verilog/cis_pkg.sv
// Types shared by the interrupt selector files
`default_nettype none
package cis_pkg;

    typedef enum logic [4:0] {
        SRC_HOST_TO_CORE = 5'h00,
        SRC_TIMER_ZERO   = 5'h01,
        SRC_TIMER_ONE    = 5'h02,
        SRC_REFRESH      = 5'h03,
        SRC_PIN4         = 5'h04,
        SRC_PIN5         = 5'h05,
        SRC_PIN6         = 5'h06,
        SRC_PIN7         = 5'h07,
        SRC_TRANSFER     = 5'h08,
        SRC_DEBUG_XFER   = 5'h09,
        SRC_DEBUG_RX     = 5'h0a,
        SRC_DEBUG_TX     = 5'h0b,
        SRC_SERIAL_TX    = 5'h0c,
        SRC_SERIAL_RX    = 5'h0d,
        SRC_PORT_PIN0    = 5'h10,
        SRC_TIMER_TWO    = 5'h13,
        SRC_TWO_WIRE     = 5'h16,
        SRC_NETWORK      = 5'h18,
        SRC_VIDEO_ONE    = 5'h1a,
        SRC_VIDEO_TWO    = 5'h1b,
        SRC_AUDIO_TX     = 5'h1c,
        SRC_AUDIO_RX     = 5'h1d
    } cis_src_type;

endpackage : cis_pkg
`default_nettype wire

// ===== verilog/cis_pin_cond.sv
// External interrupt pin conditioner: synchroniser, polarity and edge detect
`timescale 1ns/100ps
`default_nettype none
`include "cis_cfg.svh"

module cis_pin_cond
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pce,
    input  wire logic pin,
    input  wire logic falling_sel,
    output var  logic event_o
);

    logic sync1_r;
    logic sync2_r;
    logic active_prev_r;
    logic event_r;
    wire  logic active_now;

    // Falling-edge mode turns the pin round, so one detector serves both
    assign active_now = sync2_r ^ falling_sel;
    assign event_o    = event_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r       <= 1'b0;
            sync2_r       <= 1'b0;
            active_prev_r <= 1'b0;
            event_r       <= 1'b0;
        end
        else if (pce)
        begin
            sync1_r       <= pin;
            sync2_r       <= sync1_r;
            active_prev_r <= active_now;
            event_r       <= active_now & ~active_prev_r;
        end
    end

endmodule : cis_pin_cond
`default_nettype wire

// ===== verilog/cis_selector.sv
// Interrupt selector: routes event sources onto sixteen core interrupt lines
//
// What this block does
// R1 - Sixteen prioritized lines go to the core, line 0 highest and for reset, line 15 lowest.
// R2 - Lines 0 to 3 are fixed with no selector: 0 reset, 1 non-maskable, 2 and 3 always low.
// R3 - Lines 4 to 15 are each driven by the source named by their selector field.
// R4 - The low select register holds fields for lines 4 to 9 at 4:0, 9:5, 14:10, 20:16, 25:21, 30:26.
// R5 - The high select register holds fields for lines 10 to 15 at the same bit positions.
// R6 - Lines 4 to 9 reset to codes 4, 5, 6, 7, 8 and 9.
// R7 - Lines 10 to 15 reset to codes 3, 10, 11, 0, 1 and 2.
// R8 - Codes 4 to 7 route the shared port or external pin events 4 to 7, code 3 the refresh timer.
// R9 - Code 8 routes the combined transfer controller event.
// R10 - Codes 9, 10 and 11 route the debug transfer, debug exchange receive and transmit events.
// R11 - The remaining peripheral codes decode to host, timers, serial, port pin 0, bus, network, video, audio.
// R12 - Software never writes a reserved code; such a code selects nothing.
// R13 - The polarity register picks the active edge of external pins 4 to 7 before selection.
// R14 - Bits 15 and 31 of the select registers read zero; polarity resets to rising edges.
// R15 - A new selector value drives its line from the next clock cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cis_cfg.svh"

module cis_selector
#(
    parameter int NUM_EXT_PINS = `CIS_POL_WIDTH
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    input  wire logic        core_reset_event,
    input  wire logic        nmi_pin,
    input  wire logic [3:0]  ext_pin_event,
    input  wire logic [3:0]  port_pin_event,
    input  wire logic        port_pin0_event,
    input  wire logic        host_to_core_event,
    input  wire logic        timer_zero_event,
    input  wire logic        timer_one_event,
    input  wire logic        timer_two_event,
    input  wire logic        refresh_timer_event,
    input  wire logic        transfer_ctrl_event,
    input  wire logic        debug_transfer_event,
    input  wire logic        debug_exchange_rx_event,
    input  wire logic        debug_exchange_tx_event,
    input  wire logic        serial_port_tx_event,
    input  wire logic        serial_port_rx_event,
    input  wire logic        two_wire_event,
    input  wire logic        network_mgmt_event,
    input  wire logic        video_port_one_event,
    input  wire logic        video_port_two_event,
    input  wire logic        audio_tx_event,
    input  wire logic        audio_rx_event,
    output var  logic [15:0] cpu_int,
    output var  logic        irq
);

    localparam int NSEL = `CIS_NUM_LINES - `CIS_FIRST_SEL_LINE;
    localparam int SW   = `CIS_SEL_WIDTH;

    if (NUM_EXT_PINS != `CIS_POL_WIDTH)
    begin : g_bad_pins
        $error("cis_selector serves exactly four external pins");
    end

    logic [31:0] sel_high_r;
    logic [31:0] sel_low_r;
    logic [3:0]  polarity_r;
    logic [15:0] status_r;
    logic [15:0] mask_r;
    logic [15:0] cpu_int_r;
    logic        irq_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        nmi_sync1_r;
    logic        nmi_sync2_r;
    logic [31:0] src_vec;

    wire logic [3:0]  ext_cond;
    wire logic [SW-1:0] sel_field [NSEL];
    wire logic [15:0] cpu_int_nxt;
    wire logic [15:0] status_nxt;
    wire logic [15:0] int_rise;
    wire logic        hit_high;
    wire logic        hit_low;
    wire logic        hit_pol;
    wire logic        hit_stat;
    wire logic        hit_mask;
    wire logic        hit_any;
    wire logic        acc_phase;
    wire logic        acc_done;
    wire logic        wr_done;
    wire logic        rd_done;
    wire logic [31:0] rd_data;

    // R13: each pin passes its polarity before it meets the selector
    for (genvar p = 0; p < NUM_EXT_PINS; p++)
    begin : g_pin
        cis_pin_cond u_cond
        (
            .pclk        (pclk),
            .presetn     (presetn),
            .pce         (pce),
            .pin         (ext_pin_event[p]),
            .falling_sel (polarity_r[p]),
            .event_o     (ext_cond[p])
        );
    end

    // R8 R9 R10 R11 R12: unlisted codes leave their bit low
    always_comb
    begin
        src_vec = 32'h00000000;
        src_vec[cis_pkg::SRC_HOST_TO_CORE] = host_to_core_event;
        src_vec[cis_pkg::SRC_TIMER_ZERO]   = timer_zero_event;
        src_vec[cis_pkg::SRC_TIMER_ONE]    = timer_one_event;
        src_vec[cis_pkg::SRC_REFRESH]      = refresh_timer_event;
        src_vec[cis_pkg::SRC_PIN4]         = port_pin_event[0] | ext_cond[0];
        src_vec[cis_pkg::SRC_PIN5]         = port_pin_event[1] | ext_cond[1];
        src_vec[cis_pkg::SRC_PIN6]         = port_pin_event[2] | ext_cond[2];
        src_vec[cis_pkg::SRC_PIN7]         = port_pin_event[3] | ext_cond[3];
        src_vec[cis_pkg::SRC_TRANSFER]     = transfer_ctrl_event;
        src_vec[cis_pkg::SRC_DEBUG_XFER]   = debug_transfer_event;
        src_vec[cis_pkg::SRC_DEBUG_RX]     = debug_exchange_rx_event;
        src_vec[cis_pkg::SRC_DEBUG_TX]     = debug_exchange_tx_event;
        src_vec[cis_pkg::SRC_SERIAL_TX]    = serial_port_tx_event;
        src_vec[cis_pkg::SRC_SERIAL_RX]    = serial_port_rx_event;
        src_vec[cis_pkg::SRC_PORT_PIN0]    = port_pin0_event;
        src_vec[cis_pkg::SRC_TIMER_TWO]    = timer_two_event;
        src_vec[cis_pkg::SRC_TWO_WIRE]     = two_wire_event;
        src_vec[cis_pkg::SRC_NETWORK]      = network_mgmt_event;
        src_vec[cis_pkg::SRC_VIDEO_ONE]    = video_port_one_event;
        src_vec[cis_pkg::SRC_VIDEO_TWO]    = video_port_two_event;
        src_vec[cis_pkg::SRC_AUDIO_TX]     = audio_tx_event;
        src_vec[cis_pkg::SRC_AUDIO_RX]     = audio_rx_event;
    end

    // Field k of a register sits at k*5, shifted up one past bit 15
    for (genvar j = 0; j < NSEL; j++)
    begin : g_line
        localparam int K   = j % `CIS_FIELDS_PER_REG;
        localparam int LSB = K * SW + ((K >= `CIS_FIELD_GAP_IDX) ? 1 : 0);
        if (j < `CIS_FIELDS_PER_REG)
        begin : g_low
            assign sel_field[j] = sel_low_r[LSB +: SW];  // R4
        end
        else
        begin : g_high
            assign sel_field[j] = sel_high_r[LSB +: SW]; // R5
        end
        assign cpu_int_nxt[j + `CIS_FIRST_SEL_LINE] = src_vec[sel_field[j]]; // R3
    end

    // R1 R2: fixed lines take no selector
    assign cpu_int_nxt[0] = core_reset_event;
    assign cpu_int_nxt[1] = nmi_sync2_r;
    assign cpu_int_nxt[2] = 1'b0;
    assign cpu_int_nxt[3] = 1'b0;

    assign int_rise = cpu_int_nxt & ~cpu_int_r & `CIS_STAT_WMASK;

    // Bus decode
    assign hit_high  = paddr == `CIS_ADDR_SEL_HIGH;
    assign hit_low   = paddr == `CIS_ADDR_SEL_LOW;
    assign hit_pol   = paddr == `CIS_ADDR_POLARITY;
    assign hit_stat  = paddr == `CIS_ADDR_STATUS;
    assign hit_mask  = paddr == `CIS_ADDR_MASK;
    assign hit_any   = hit_high | hit_low | hit_pol | hit_stat | hit_mask;
    assign acc_phase = psel & penable;
    assign acc_done  = acc_phase & pready_r;
    assign wr_done   = acc_done & pwrite & hit_any;
    assign rd_done   = acc_done & ~pwrite;

    assign rd_data = hit_high ? sel_high_r :
                     hit_low  ? sel_low_r :
                     hit_pol  ? {28'h0000000, polarity_r} :
                     hit_stat ? {16'h0000, status_r} :
                     hit_mask ? {16'h0000, mask_r} : 32'h00000000;

    // Clear only what the read returned, so a bit set during the access survives
    assign status_nxt = ((rd_done & hit_stat) ? (status_r & ~prdata_r[15:0]) : status_r) | int_rise;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;
    assign cpu_int = cpu_int_r;
    assign irq     = irq_r;

    // Two-cycle access phase: answer is registered to keep outputs on flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h00000000;
        end
        else if (pce)
        begin
            pready_r  <= acc_phase & ~pready_r;
            pslverr_r <= acc_phase & ~pready_r & ~hit_any;
            prdata_r  <= (acc_phase & ~pready_r & ~pwrite) ? rd_data : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_high_r <= `CIS_RST_SEL_HIGH; // R7
            sel_low_r  <= `CIS_RST_SEL_LOW;  // R6
            polarity_r <= `CIS_RST_POLARITY; // R14
            mask_r     <= `CIS_RST_MASK;
        end
        else if (pce && wr_done)
        begin
            if (hit_high)
                sel_high_r <= pwdata & `CIS_SEL_WMASK; // R14
            if (hit_low)
                sel_low_r <= pwdata & `CIS_SEL_WMASK;  // R14
            if (hit_pol)
                polarity_r <= pwdata[3:0];             // R13
            if (hit_mask)
                mask_r <= pwdata[15:0] & `CIS_STAT_WMASK;
        end
    end

    // R15: line register follows the selection one edge later
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nmi_sync1_r <= 1'b0;
            nmi_sync2_r <= 1'b0;
            cpu_int_r   <= 16'h0000;
            status_r    <= 16'h0000;
            irq_r       <= 1'b0;
        end
        else if (pce)
        begin
            nmi_sync1_r <= nmi_pin;
            nmi_sync2_r <= nmi_sync1_r;
            cpu_int_r   <= cpu_int_nxt;
            status_r    <= status_nxt;
            irq_r       <= |(status_nxt & mask_r);
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    fixed_lines_low_a: assert property (cpu_int[3:2] == 2'b00) // R2
        else $error("reserved lines 2 or 3 driven");

    reset_line_a: assert property (pce |=> cpu_int[0] == $past(core_reset_event)) // R1
        else $error("line 0 does not follow the reset event");

    route_line4_a: assert property (pce |=> cpu_int[4] == $past(src_vec[sel_low_r[4:0]])) // R3
        else $error("line 4 does not follow its selected source");

    gap_bits_zero_a: assert property ((sel_low_r[15] | sel_low_r[31] | sel_high_r[15] | sel_high_r[31]) == 1'b0) // R14
        else $error("unused select bits set");

    reset_values_a: assert property ($rose(presetn) |-> // R6
        sel_low_r == `CIS_RST_SEL_LOW && sel_high_r == `CIS_RST_SEL_HIGH && polarity_r == `CIS_RST_POLARITY)
        else $error("select registers left reset with wrong values");

    host_code_a: assert property ((pce && sel_high_r[20:16] == 5'h00) ##1 pce |-> // R11
        cpu_int[13] == $past(host_to_core_event))
        else $error("code 0 on line 13 does not route the host event");

    transfer_code_a: assert property ((pce && sel_low_r[25:21] == 5'h08 && transfer_ctrl_event) |=> cpu_int[8]) // R9
        else $error("code 8 on line 8 does not route the transfer event");

    debug_code_a: assert property ((pce && sel_high_r[9:5] == 5'h0a && debug_exchange_rx_event) |=> cpu_int[11]) // R10
        else $error("code 10 on line 11 does not route debug receive");

    refresh_code_a: assert property ((pce && sel_high_r[4:0] == 5'h03 && !refresh_timer_event) |=> !cpu_int[10]) // R8
        else $error("line 10 high without refresh event");

    reserved_code_a: assert property ((pce && sel_low_r[4:0] == 5'h0e) |=> !cpu_int[4]) // R12
        else $error("reserved code drove line 4");

    new_select_a: assert property ((pce && wr_done && hit_low) |=> // R15
        sel_low_r[4:0] == $past(pwdata[4:0]) ##1 (cpu_int[4] == $past(src_vec[sel_low_r[4:0]]) || !$past(pce)))
        else $error("new selection not in force one cycle after the write");

    polarity_write_a: assert property ((pce && wr_done && hit_pol) |=> polarity_r == $past(pwdata[3:0])) // R13
        else $error("polarity register missed a write");

    answer_time_a: assert property ((pce && acc_phase && !pready) |=> pready ##1 !pready)
        else $error("access phase not answered in one cycle");

    irq_level_a: assert property (pce |=> irq == |($past(status_nxt) & $past(mask_r)))
        else $error("interrupt output disagrees with status and mask");

endmodule : cis_selector
`default_nettype wire

// ===== sim/cis_src_model.sv
// Far-side event source model: one source pulses for a cycle per request
`timescale 1ns/100ps
`default_nettype none

module cis_src_model
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        fire,
    input  wire logic [4:0]  code,
    output var  logic [31:0] src
);
    // Single-cycle pulse, so a line that sticks shows up as a second cpu_int bit at the next pulse check
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            src <= 32'h00000000;
        else
            src <= fire ? (32'h00000001 << code) : 32'h00000000;
    end
endmodule : cis_src_model

`default_nettype wire

// ===== sim/cpu_interrupt_selector_tb.sv
// Self-checking bench for the interrupt selector
`timescale 1ns/100ps
`default_nettype none
`include "cis_cfg.svh"

module cpu_interrupt_selector_tb;
    logic        pclk;
    logic        presetn;
    logic        pce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        core_reset_event;
    logic        nmi_pin;
    logic [3:0]  ext_pin_event;
    logic        fire;
    logic [4:0]  code;
    logic [31:0] src;
    logic [15:0] cpu_int;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          n_errors;
    int          n_compared;
    int          n_cycles;
    logic [4:0]  dflt [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02};
    logic [4:0]  legal [22] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
                                5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h13, 5'h16, 5'h18, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    cis_src_model model (.pclk(pclk), .presetn(presetn), .fire(fire), .code(code), .src(src));

    cis_selector dut
    (
        .pclk                    (pclk),
        .presetn                 (presetn),
        .pce                     (pce),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .core_reset_event        (core_reset_event),
        .nmi_pin                 (nmi_pin),
        .ext_pin_event           (ext_pin_event),
        .port_pin_event          (src[7:4]),
        .port_pin0_event         (src[16]),
        .host_to_core_event      (src[0]),
        .timer_zero_event        (src[1]),
        .timer_one_event         (src[2]),
        .timer_two_event         (src[19]),
        .refresh_timer_event     (src[3]),
        .transfer_ctrl_event     (src[8]),
        .debug_transfer_event    (src[9]),
        .debug_exchange_rx_event (src[10]),
        .debug_exchange_tx_event (src[11]),
        .serial_port_tx_event    (src[12]),
        .serial_port_rx_event    (src[13]),
        .two_wire_event          (src[22]),
        .network_mgmt_event      (src[24]),
        .video_port_one_event    (src[26]),
        .video_port_two_event    (src[27]),
        .audio_tx_event          (src[28]),
        .audio_rx_event          (src[29]),
        .cpu_int                 (cpu_int),
        .irq                     (irq)
    );

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Hang is cut by the cycle ceiling, not here
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rdc

    task automatic pulse(input logic [4:0] c, input logic [15:0] exp);
        @(posedge pclk);
        fire <= 1'b1;
        code <= c;
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
        #1 chk({16'h0000, cpu_int}, {16'h0000, exp});
    endtask : pulse

    task automatic pin(input logic v, input logic [31:0] exp);
        @(posedge pclk);
        ext_pin_event <= {3'h0, v};
        repeat (8) @(posedge pclk);
        rdc(`CIS_ADDR_STATUS, exp);
    endtask : pin

    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge pclk);
        #1 chk({31'h00000000, irq}, {31'h00000000, exp});
    endtask : irq_chk

    function automatic logic [31:0] rep(input logic [4:0] c);
        return {1'b0, c, c, c, 1'b0, c, c, c};
    endfunction : rep

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // About 470 cycles of tests; some forty times that means a hang
    always @(posedge pclk)
    begin
        n_cycles++;
        if (n_cycles == 20000)
        begin
            n_errors++;
            stop_test();
        end
    end

    initial
    begin
        n_errors = 0;
        n_compared = 0;
        n_cycles = 0;
        presetn = 1'b0;
        pce = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h00000000;
        pwdata = 32'h00000000;
        core_reset_event = 1'b0;
        nmi_pin = 1'b0;
        ext_pin_event = 4'h0;
        fire = 1'b0;
        code = 5'h00;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(`CIS_ADDR_SEL_HIGH, 32'h08202d43);
        rdc(`CIS_ADDR_SEL_LOW, 32'h250718a4);
        rdc(`CIS_ADDR_POLARITY, 32'h00000000);
        for (int i = 0; i < 12; i++)
            pulse(dflt[i], 16'h0001 << (i + 4));
        $display("test reset and default routing done");
        @(posedge pclk);
        core_reset_event <= 1'b1;
        @(posedge pclk);
        core_reset_event <= 1'b0;
        nmi_pin <= 1'b1;
        #1 chk({16'h0000, cpu_int}, 32'h00000001);
        repeat (4) @(posedge pclk);
        #1 chk({16'h0000, cpu_int}, 32'h00000002);
        @(posedge pclk);
        nmi_pin <= 1'b0;
        $display("test fixed lines done");
        apb(1'b0, `CIS_ADDR_STATUS, 32'h00000000);
        pin(1'b1, 32'h00000010);
        pin(1'b0, 32'h00000000);
        apb(1'b1, `CIS_ADDR_POLARITY, 32'h00000001);
        rdc(`CIS_ADDR_POLARITY, 32'h00000001);
        repeat (8) @(posedge pclk);
        apb(1'b0, `CIS_ADDR_STATUS, 32'h00000000);
        pin(1'b1, 32'h00000000);
        pin(1'b0, 32'h00000010);
        $display("test pin polarity done");
        apb(1'b1, `CIS_ADDR_MASK, 32'h0000ffff);
        rdc(`CIS_ADDR_MASK, 32'h0000fff0);
        apb(1'b0, `CIS_ADDR_STATUS, 32'h00000000);
        pulse(5'h01, 16'h4000);
        irq_chk(1'b1);
        rdc(`CIS_ADDR_STATUS, 32'h00004000);
        irq_chk(1'b0);
        apb(1'b1, `CIS_ADDR_MASK, 32'h00000000);
        pulse(5'h01, 16'h4000);
        irq_chk(1'b0);
        rdc(`CIS_ADDR_STATUS, 32'h00004000);
        $display("test interrupt status and mask done");
        apb(1'b1, `CIS_ADDR_SEL_HIGH, 32'hf7bdf7bd);
        rdc(`CIS_ADDR_SEL_HIGH, 32'h77bd77bd);
        apb(1'b1, `CIS_ADDR_SEL_LOW, 32'hf7bdf7bd);
        rdc(`CIS_ADDR_SEL_LOW, 32'h77bd77bd);
        foreach (legal[i])
        begin
            apb(1'b1, `CIS_ADDR_SEL_LOW, rep(legal[i]));
            apb(1'b1, `CIS_ADDR_SEL_HIGH, rep(legal[i]));
            pulse(legal[i], 16'hfff0);
        end
        $display("test every source code done");
        rdc(`CIS_ADDR_STATUS, 32'h0000fff0);
        @(posedge pclk);
        pce <= 1'b0;
        // Frozen block must neither route nor record the pulse
        pulse(5'h1d, 16'h0000);
        @(posedge pclk);
        pce <= 1'b1;
        rdc(`CIS_ADDR_STATUS, 32'h00000000);
        $display("test clock enable hold done");
        apb(1'b1, 32'h019c0014, 32'h0000ffff);
        chk({31'h00000000, err}, 32'h00000001);
        apb(1'b0, 32'h019c0014, 32'h00000000);
        chk(rd, 32'h00000000);
        chk({31'h00000000, err}, 32'h00000001);
        $display("test unmapped address done");
        stop_test();
    end
endmodule : cpu_interrupt_selector_tb

`default_nettype wire
